// ### design/hdp_cfg.svh
// Purpose: constants of the headphone depop sequencer (offsets, fields, resets, times)
// Assumes: 50 MHz core clock, 47 uF coupling capacitor
// Notes: register indices are word indices; byte address is four times the index
//
// Overview of operation
// - bits 1:0 select 2k, 6k or 25k resistor
// - bits 5:2 set slow-charge length in constants
// - no signal reaches driver while slow charging
// - bits 7:6 set soft-step interval 0/50/100/200ms
// - offset attenuation steps down once per interval
// - soft-stepping only on initial signal routing
// - flags 7:6 set when soft-stepping completes
`ifndef HDP_CFG_SVH
`define HDP_CFG_SVH

// ------------------------------------------------------------
// register indices and reset values
// ------------------------------------------------------------
`define HDP_IDX_DEPOP 8'h14
`define HDP_IDX_FLAGS 8'h3F
`define HDP_IDX_DRVCTL 8'h40
`define HDP_IDX_GAIN 8'h41
`define HDP_DEPOP_RST 8'h00
`define HDP_DRVCTL_RST 8'h00
`define HDP_GAIN_RST 6'h00

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define HDP_RPOP_LSB 0
`define HDP_NCODE_LSB 2
`define HDP_STEP_LSB 6
`define HDP_FLAG_LEFT 7
`define HDP_FLAG_RIGHT 6
`define HDP_RPOP_25K 2'h2
`define HDP_RPOP_6K 2'h1
`define HDP_NCODE_LONGEST 4'hC

// ------------------------------------------------------------
// times (time constant = resistor x 47 uF)
// ------------------------------------------------------------
`define HDP_CLK_MHZ 50
`define HDP_TAU_2K_US 94000
`define HDP_TAU_6K_US 282000
`define HDP_TAU_25K_US 1175000
`define HDP_STEP_50_MS 50
`define HDP_STEP_100_MS 100
`define HDP_STEP_200_MS 200
`define HDP_ATTEN_START 6'h3F

`endif

// ### design/hdp_pkg.sv
// Purpose: types and shared decode of the headphone depop sequencer
// Assumes: nothing beyond the constants header
// Notes: charge length is counted in eighths of a time constant
`default_nettype none

package hdp_pkg;

	typedef enum logic [1:0] {ST_OFF, ST_CHARGE, ST_STEP, ST_ON} hdp_state_e;
	typedef logic [5:0] hdp_gain_t;

	// slow-charge code to eighths of a time constant; long codes clamp for 25k
	function automatic logic [8:0] hdp_eighths(input logic [3:0] code, input logic isLong);
		logic [8:0] e;
		case (code)
			4'h0: e = 9'h000;
			4'h1: e = 9'h004;
			4'h2: e = 9'h005;
			4'h3: e = 9'h006;
			4'h4: e = 9'h007;
			4'h5: e = 9'h008;
			4'h6: e = 9'h010;
			4'h7: e = 9'h018;
			4'h8: e = 9'h020;
			4'h9: e = 9'h028;
			4'hA: e = 9'h030;
			4'hB: e = 9'h038;
			4'hC: e = 9'h040;
			4'hD: e = isLong ? 9'h040 : 9'h080;
			4'hE: e = isLong ? 9'h040 : 9'h0C0;
			default: e = isLong ? 9'h040 : 9'h100;
		endcase
		return e;
	endfunction

endpackage

`default_nettype wire

// ### design/hdp_seq_if.sv
// Purpose: carrier between sequencer control, charge timer and soft stepper
// Assumes: all signals in the core clock domain
// Notes: interval counts are held stable by the controller while in use
`default_nettype none

interface hdp_seq_if;
	logic chargeStart;
	logic [31:0] eighthCycles;
	logic [8:0] chargeUnits;
	logic chargeDone;
	logic stepStart;
	logic [31:0] stepCycles;
	logic stepDone;
	logic [5:0] offsetAtten;

	modport ctrl(output chargeStart, eighthCycles, chargeUnits, stepStart, stepCycles,
		input chargeDone, stepDone, offsetAtten);
	modport timer(input chargeStart, eighthCycles, chargeUnits, output chargeDone);
	modport stepper(input stepStart, stepCycles, output stepDone, offsetAtten);
endinterface

`default_nettype wire

// ### design/hdp_charge_timer.sv
// Purpose: slow-charge timer counting eighths of a time constant
// Assumes: eighthCycles at least one, stable while armed
// Notes: done is a level held until the next start
`default_nettype none

module hdp_charge_timer (
	input wire logic core_clk,
	input wire logic rst,
	hdp_seq_if.timer seq
);
	logic armed;
	logic next_armed;
	logic [31:0] pre;
	logic [31:0] next_pre;
	logic [8:0] units;
	logic [8:0] next_units;

	// prescaler yields one tick per eighth constant, units count those ticks
	always_comb begin
		next_armed = armed;
		next_pre = pre;
		next_units = units;
		if (seq.chargeStart) begin
			next_armed = 1'h1;
			next_units = seq.chargeUnits;
			next_pre = seq.eighthCycles - 32'h1;
		end else if (armed && units != 9'h0) begin
			if (pre == 32'h0) begin
				next_pre = seq.eighthCycles - 32'h1;
				next_units = units - 9'h1;
			end else begin
				next_pre = pre - 32'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			armed <= 1'h0;
			pre <= 32'h0;
			units <= 9'h0;
		end else begin
			armed <= next_armed;
			pre <= next_pre;
			units <= next_units;
		end
	end

	// release the driver once the whole count has elapsed
	assign seq.chargeDone = armed && (units == 9'h0);

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_charge_load;
		@(posedge core_clk) disable iff (rst)
		seq.chargeStart |=> (units == $past(seq.chargeUnits)) && armed;
	endproperty
	a_charge_load: assert property (p_charge_load) else $error("charge count not loaded");

	property p_charge_tick;
		@(posedge core_clk) disable iff (rst)
		(armed && units != 9'h0 && pre == 32'h0 && !seq.chargeStart)
			|=> units == $past(units) - 9'h1;
	endproperty
	a_charge_tick: assert property (p_charge_tick) else $error("charge unit not consumed");

endmodule

`default_nettype wire

// ### design/hdp_soft_stepper.sv
// Purpose: DC-offset soft stepper lowering attenuation once per interval
// Assumes: stepCycles zero means stepping disabled
// Notes: attenuation rests at zero until the next start
`include "hdp_cfg.svh"
`default_nettype none

module hdp_soft_stepper (
	input wire logic core_clk,
	input wire logic rst,
	hdp_seq_if.stepper seq
);
	logic armed;
	logic next_armed;
	logic [31:0] pre;
	logic [31:0] next_pre;
	hdp_pkg::hdp_gain_t atten;
	hdp_pkg::hdp_gain_t next_atten;

	// load full attenuation, then remove one step each interval
	always_comb begin
		next_armed = armed;
		next_pre = pre;
		next_atten = atten;
		if (seq.stepStart) begin
			next_armed = 1'h1;
			next_pre = seq.stepCycles - 32'h1;
			next_atten = (seq.stepCycles == 32'h0) ? 6'h00 : `HDP_ATTEN_START;
		end else if (armed && atten != 6'h00) begin
			if (pre == 32'h0) begin
				next_pre = seq.stepCycles - 32'h1;
				next_atten = atten - 6'h01;
			end else begin
				next_pre = pre - 32'h1;
			end
		end
	end

	// attenuation held high from reset so nothing leaks before a start
	always_ff @(posedge core_clk) begin
		if (rst) begin
			armed <= 1'h0;
			pre <= 32'h0;
			atten <= `HDP_ATTEN_START;
		end else begin
			armed <= next_armed;
			pre <= next_pre;
			atten <= next_atten;
		end
	end

	assign seq.stepDone = armed && (atten == 6'h00);
	assign seq.offsetAtten = atten;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_step_start;
		@(posedge core_clk) disable iff (rst)
		(seq.stepStart && seq.stepCycles != 32'h0) |=> atten == `HDP_ATTEN_START;
	endproperty
	a_step_start: assert property (p_step_start) else $error("step did not start high");

	property p_step_pace;
		@(posedge core_clk) disable iff (rst)
		(armed && !seq.stepStart && pre != 32'h0) |=> atten == $past(atten);
	endproperty
	a_step_pace: assert property (p_step_pace) else $error("step taken before interval");

endmodule

`default_nettype wire

// ### design/hdp_depop_sequencer.sv
// Purpose: pop-free power-up sequencer for the two headphone drivers
// Assumes: Avalon-MM slave with byte addresses, core clock 50 MHz
// Notes: both drivers share one charge and step sequence
`include "hdp_cfg.svh"
`default_nettype none

module hdp_depop_sequencer #(
	parameter int unsigned EIGHTH_2K = (`HDP_TAU_2K_US * `HDP_CLK_MHZ + 7) / 8,
	parameter int unsigned EIGHTH_6K = (`HDP_TAU_6K_US * `HDP_CLK_MHZ + 7) / 8,
	parameter int unsigned EIGHTH_25K = (`HDP_TAU_25K_US * `HDP_CLK_MHZ + 7) / 8,
	parameter int unsigned STEP_50 = `HDP_STEP_50_MS * 1000 * `HDP_CLK_MHZ,
	parameter int unsigned STEP_100 = `HDP_STEP_100_MS * 1000 * `HDP_CLK_MHZ,
	parameter int unsigned STEP_200 = `HDP_STEP_200_MS * 1000 * `HDP_CLK_MHZ
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [1:0] resistorSel,
	output logic chargeMode,
	output logic pathEnable,
	output logic leftPowerOn,
	output logic rightPowerOn,
	output logic [5:0] driverGain,
	output logic [5:0] offsetAtten
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	hdp_seq_if seq ();

	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	logic [7:0] depopCtl;
	logic [7:0] next_depopCtl;
	logic [7:0] drvCtl;
	logic [7:0] next_drvCtl;
	hdp_pkg::hdp_gain_t gainReg;
	hdp_pkg::hdp_gain_t next_gainReg;
	hdp_pkg::hdp_state_e state;
	hdp_pkg::hdp_state_e next_state;
	logic [1:0] latRpop;
	logic [1:0] next_latRpop;
	logic [31:0] latEighth;
	logic [31:0] next_latEighth;
	logic [8:0] latUnits;
	logic [8:0] next_latUnits;
	logic [31:0] latStep;
	logic [31:0] next_latStep;
	logic [7:0] flags;
	logic wordOk;
	logic [7:0] index;
	logic [1:0] powerReq;
	logic startSeq;
	logic doWrite;

	// ------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------
	// misaligned byte addresses fall into the unmapped space
	assign wordOk = (avs_address[1:0] == 2'h0);
	assign index = avs_address[9:2];
	assign doWrite = avs_write && ack && wordOk && avs_byteenable[0];

	// one wait cycle: read data is staged first, offered while waitrequest is low
	assign avs_waitrequest = (avs_read || avs_write) && !ack;

	always_comb begin
		next_ack = (avs_read || avs_write) && !ack;
		next_readdata = avs_readdata;
		if (avs_read && !ack) begin
			next_readdata = 32'h0;
			if (wordOk) begin
				case (index)
					`HDP_IDX_DEPOP: next_readdata = {24'h0, depopCtl};
					`HDP_IDX_FLAGS: next_readdata = {24'h0, flags};
					`HDP_IDX_DRVCTL: next_readdata = {24'h0, drvCtl};
					`HDP_IDX_GAIN: next_readdata = {26'h0, gainReg};
					default: next_readdata = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack <= 1'h0;
			avs_readdata <= 32'h0;
		end else begin
			ack <= next_ack;
			avs_readdata <= next_readdata;
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	// writes land on the answering edge; the flag register ignores writes
	always_comb begin
		next_depopCtl = depopCtl;
		next_drvCtl = drvCtl;
		next_gainReg = gainReg;
		if (doWrite) begin
			case (index)
				`HDP_IDX_DEPOP: next_depopCtl = avs_writedata[7:0];
				`HDP_IDX_DRVCTL: next_drvCtl = {6'h00, avs_writedata[1:0]};
				`HDP_IDX_GAIN: next_gainReg = avs_writedata[5:0];
				default: next_depopCtl = depopCtl;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			depopCtl <= `HDP_DEPOP_RST;
			drvCtl <= `HDP_DRVCTL_RST;
			gainReg <= `HDP_GAIN_RST;
		end else begin
			depopCtl <= next_depopCtl;
			drvCtl <= next_drvCtl;
			gainReg <= next_gainReg;
		end
	end

	// ------------------------------------------------------------
	// sequence control
	// ------------------------------------------------------------
	assign powerReq = drvCtl[1:0];
	assign startSeq = (state == hdp_pkg::ST_OFF) && (powerReq != 2'h0);

	// snapshot the depop fields at power-up so later writes cannot upset a run
	always_comb begin
		next_latRpop = latRpop;
		next_latEighth = latEighth;
		next_latUnits = latUnits;
		next_latStep = latStep;
		if (startSeq) begin
			next_latRpop = depopCtl[`HDP_RPOP_LSB +: 2];
			case (depopCtl[`HDP_RPOP_LSB +: 2])
				2'h0: next_latEighth = 32'(EIGHTH_2K);
				`HDP_RPOP_6K: next_latEighth = 32'(EIGHTH_6K);
				default: next_latEighth = 32'(EIGHTH_25K);
			endcase
			// reserved code 11 is timed as 25k, the longest and safest
			next_latUnits = hdp_pkg::hdp_eighths(depopCtl[`HDP_NCODE_LSB +: 4],
				depopCtl[`HDP_RPOP_LSB + 1]);
			case (depopCtl[`HDP_STEP_LSB +: 2])
				2'h1: next_latStep = 32'(STEP_50);
				2'h2: next_latStep = 32'(STEP_100);
				2'h3: next_latStep = 32'(STEP_200);
				default: next_latStep = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			latRpop <= 2'h0;
			latEighth <= 32'h1;
			latUnits <= 9'h0;
			latStep <= 32'h0;
		end else begin
			latRpop <= next_latRpop;
			latEighth <= next_latEighth;
			latUnits <= next_latUnits;
			latStep <= next_latStep;
		end
	end

	// off -> slow charge -> soft step -> steady; dropping both power bits aborts
	always_comb begin
		next_state = state;
		case (state)
			hdp_pkg::ST_OFF: begin
				if (powerReq != 2'h0) begin
					next_state = hdp_pkg::ST_CHARGE;
				end
			end
			hdp_pkg::ST_CHARGE: begin
				if (powerReq == 2'h0) begin
					next_state = hdp_pkg::ST_OFF;
				end else if (seq.chargeDone) begin
					next_state = hdp_pkg::ST_STEP;
				end
			end
			hdp_pkg::ST_STEP: begin
				if (powerReq == 2'h0) begin
					next_state = hdp_pkg::ST_OFF;
				end else if (seq.stepDone) begin
					next_state = hdp_pkg::ST_ON;
				end
			end
			hdp_pkg::ST_ON: begin
				if (powerReq == 2'h0) begin
					next_state = hdp_pkg::ST_OFF;
				end
			end
			default: next_state = hdp_pkg::ST_OFF;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			state <= hdp_pkg::ST_OFF;
		end else begin
			state <= next_state;
		end
	end

	// timers are started on the entry edge of their state
	assign seq.chargeStart = (state == hdp_pkg::ST_OFF) && (powerReq != 2'h0);
	assign seq.eighthCycles = next_latEighth;
	assign seq.chargeUnits = next_latUnits;
	assign seq.stepStart = (state == hdp_pkg::ST_CHARGE) && (powerReq != 2'h0)
		&& seq.chargeDone;
	assign seq.stepCycles = latStep;

	hdp_charge_timer u_timer (
		.core_clk(core_clk),
		.rst(rst),
		.seq(seq)
	);

	hdp_soft_stepper u_stepper (
		.core_clk(core_clk),
		.rst(rst),
		.seq(seq)
	);

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	// all status derives from registered state, so outputs are glitch free
	assign flags = {(state == hdp_pkg::ST_ON) && drvCtl[0], (state == hdp_pkg::ST_ON) && drvCtl[1],
		6'h00};
	assign resistorSel = latRpop;
	assign chargeMode = (state == hdp_pkg::ST_CHARGE);
	assign pathEnable = (state == hdp_pkg::ST_STEP) || (state == hdp_pkg::ST_ON);
	assign leftPowerOn = drvCtl[0] && (state != hdp_pkg::ST_OFF);
	assign rightPowerOn = drvCtl[1] && (state != hdp_pkg::ST_OFF);
	// gain changes after power-up pass straight through without stepping
	assign driverGain = gainReg;
	assign offsetAtten = seq.offsetAtten;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	property p_no_signal_charging;
		@(posedge core_clk) disable iff (rst)
		chargeMode |-> !pathEnable;
	endproperty
	a_no_signal_charging: assert property (p_no_signal_charging) else $error("path open in charge");

	property p_path_after_charge;
		@(posedge core_clk) disable iff (rst)
		$rose(pathEnable) |-> $past(chargeMode) && $past(seq.chargeDone);
	endproperty
	a_path_after_charge: assert property (p_path_after_charge) else $error("path opened early");

	property p_rpop_latched;
		@(posedge core_clk) disable iff (rst)
		startSeq |=> resistorSel == $past(depopCtl[1:0]);
	endproperty
	a_rpop_latched: assert property (p_rpop_latched) else $error("resistor select wrong");

	property p_flags_on_done;
		@(posedge core_clk) disable iff (rst)
		$rose(flags[`HDP_FLAG_LEFT]) |-> $past(seq.stepDone) || $past(state == hdp_pkg::ST_ON);
	endproperty
	a_flags_on_done: assert property (p_flags_on_done) else $error("flag before stepping done");

	property p_no_step_when_on;
		@(posedge core_clk) disable iff (rst)
		(state == hdp_pkg::ST_ON) |-> offsetAtten == 6'h00 && driverGain == gainReg;
	endproperty
	a_no_step_when_on: assert property (p_no_step_when_on) else $error("stepping after routing");

	property p_long_clamp;
		@(posedge core_clk) disable iff (rst)
		(startSeq && depopCtl[1:0] == `HDP_RPOP_25K && depopCtl[5:2] > `HDP_NCODE_LONGEST)
			|=> latUnits == 9'h040;
	endproperty
	a_long_clamp: assert property (p_long_clamp) else $error("25k long code not clamped");

	property p_bus_one_wait;
		@(posedge core_clk) disable iff (rst)
		((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest;
	endproperty
	a_bus_one_wait: assert property (p_bus_one_wait) else $error("bus answer late");

	c_reach_on: cover property (@(posedge core_clk) disable iff (rst)
		$rose(state == hdp_pkg::ST_ON));
	c_abort_charge: cover property (@(posedge core_clk) disable iff (rst)
		chargeMode ##1 (state == hdp_pkg::ST_OFF));
	c_step_disabled: cover property (@(posedge core_clk) disable iff (rst)
		seq.stepStart && seq.stepCycles == 32'h0);

endmodule

`default_nettype wire

// ### test/hdp_depop_sequencer_bench.sv
// Purpose: self-checking bench for the headphone depop sequencer
// Assumes: small charge and step parameters so each power-up stays short
// Notes: reads and charge lengths are noted in queues and judged by a watcher
`default_nettype none

module hdp_depop_sequencer_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// constants and signals
	// ------------------------------------------------------------
	localparam int E2K = 4, E6K = 6, E25K = 8, S50 = 3, S100 = 5, S200 = 7;
	localparam int LIMIT = 40000;
	localparam logic [9:0] A_DEPOP = 10'h050, A_FLAGS = 10'h0FC, A_DRV = 10'h100;
	localparam logic [9:0] A_GAIN = 10'h104, A_NONE = 10'h3FC;
	// eighths of a time constant for each slow-charge code
	localparam int UNITS [16] = '{0, 4, 5, 6, 7, 8, 16, 24, 32, 40, 48, 56, 64, 128, 192, 256};

	logic core_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic chargeMode, pathEnable, leftPowerOn, rightPowerOn;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, seed;
	logic [3:0] avs_byteenable;
	logic [1:0] resistorSel;
	logic [5:0] driverGain, offsetAtten, prevAtten;
	int fails, checks, cycles, chargeRun, stepGap, stepExp;
	logic [31:0] rdQ [$];
	int chargeQ [$];

	hdp_depop_sequencer #(.EIGHTH_2K(E2K), .EIGHTH_6K(E6K), .EIGHTH_25K(E25K),
		.STEP_50(S50), .STEP_100(S100), .STEP_200(S200)) u_dut (
		.core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .resistorSel(resistorSel),
		.chargeMode(chargeMode), .pathEnable(pathEnable), .leftPowerOn(leftPowerOn),
		.rightPowerOn(rightPowerOn), .driverGain(driverGain), .offsetAtten(offsetAtten));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return s[31] ? ({s[30:0], 1'h0} ^ 32'h04C11DB7) : {s[30:0], 1'h0};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// one bus cycle; waitrequest is sampled at each rising edge, as a master does
	task automatic bus(input logic wr, input logic [9:0] a, input logic [7:0] d,
		input logic [3:0] be);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= {24'h000000, d};
		avs_byteenable <= be;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'h0) @(posedge core_clk);
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		// one idle cycle keeps the next request apart from this one
		@(posedge core_clk);
	endtask

	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		bus(1'b1, a, d, 4'hF);
	endtask

	task automatic rd(input logic [9:0] a, input logic [31:0] exp);
		rdQ.push_back(exp);
		bus(1'b0, a, 8'h00, 4'hF);
	endtask

	// full power-up, steady-state checks, then power-down
	task automatic power_up(input logic [7:0] dep, input int stepCyc);
		int units, eighth, i;
		eighth = (dep[1:0] == 2'h0) ? E2K : (dep[1:0] == 2'h1) ? E6K : E25K;
		units = UNITS[dep[5:2]];
		if (dep[1] && dep[5:2] > 4'hC) units = 64; // long codes clamp with 25k
		wr(A_DEPOP, dep);
		stepExp = stepCyc;
		chargeQ.push_back(units * eighth + 1);
		wr(A_DRV, 8'h03);
		if (units > 0) rd(A_FLAGS, 32'h00000000);
		i = 0;
		while (!(pathEnable === 1'h1 && offsetAtten === 6'h00 && chargeMode === 1'h0)
			&& i < 3000) begin
			@(negedge core_clk);
			i++;
		end
		@(posedge core_clk);
		check(32'(i < 3000), 32'h1);
		check(32'(resistorSel), 32'(dep[1:0]));
		check(32'({leftPowerOn, rightPowerOn}), 32'h3);
		rd(A_FLAGS, 32'h000000C0);
		wr(A_GAIN, 8'h2A);
		rd(A_GAIN, 32'h0000002A);
		repeat (4) @(posedge core_clk);
		check(32'(driverGain), 32'h2A);
		check(32'({chargeMode, offsetAtten}), 32'h0);
		wr(A_DRV, 8'h00);
		rd(A_FLAGS, 32'h00000000);
		check(32'({leftPowerOn, rightPowerOn}), 32'h0);
	endtask

	// ------------------------------------------------------------
	// clock, timeout and watcher of results
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			end_of_test();
		end
	end

	// read data is taken at the rising edge that ends the wait, like the master
	always @(posedge core_clk) begin
		if (rst === 1'h0 && avs_read === 1'h1 && avs_waitrequest === 1'h0) begin
			if (rdQ.size() > 0) check(avs_readdata, rdQ.pop_front());
			else check(32'h0, 32'h1);
		end
	end

	// timing judged mid-cycle, away from the edge that launches it
	always @(negedge core_clk) begin
		if (rst) begin
			chargeRun = 0;
			stepGap = 0;
			prevAtten = offsetAtten;
		end else begin
			if (chargeMode === 1'h1) begin
				chargeRun++;
				check(32'(pathEnable), 32'h0);
			end else if (chargeRun > 0) begin
				if (chargeQ.size() > 0) check(32'(chargeRun), 32'(chargeQ.pop_front()));
				else check(32'h0, 32'h1);
				chargeRun = 0;
			end
			stepGap++;
			if (offsetAtten !== prevAtten) begin
				if (stepExp != 0 && prevAtten != 6'h3F && offsetAtten != 6'h3F) begin
					check(32'(stepGap), 32'(stepExp));
					check(32'(offsetAtten), 32'(prevAtten - 6'h01));
				end
				stepGap = 0;
				prevAtten = offsetAtten;
			end
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'h1;
		avs_address = 10'h000;
		avs_read = 1'h0;
		avs_write = 1'h0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'h0;
		seed = 32'h00014341;
		stepExp = 0;
		repeat (20) @(posedge core_clk);
		rst <= 1'h0;
		@(posedge core_clk);
		check(32'({chargeMode, pathEnable, offsetAtten}), 32'h3F);
		rd(A_DEPOP, 32'h0);
		rd(A_FLAGS, 32'h0);
		rd(A_DRV, 32'h0);
		rd(A_GAIN, 32'h0);
		// random readback while powered off
		repeat (6) begin
			seed = lfsr(seed);
			wr(A_DEPOP, seed[7:0]);
			rd(A_DEPOP, {24'h000000, seed[7:0]});
			wr(A_GAIN, seed[15:8]);
			rd(A_GAIN, {26'h0, seed[13:8]});
		end
		// refused writes leave state untouched
		wr(A_DEPOP, 8'h5A);
		bus(1'h1, 10'h051, 8'hFF, 4'hF);
		bus(1'h1, A_DEPOP, 8'hFF, 4'h0);
		wr(A_FLAGS, 8'hFF);
		rd(A_DEPOP, 32'h0000005A);
		rd(A_FLAGS, 32'h0);
		rd(A_NONE, 32'h0);
		rd(10'h051, 32'h0);
		// no charge-pump enable exists here: the unipolar hookup is taken as given
		// every charge code with the smallest resistor; code zero leaves charge mode on for one cycle only
		for (int c = 0; c < 16; c++) begin
			power_up({2'h0, 4'(c), 2'h0}, 0);
		end
		power_up(8'h36, 0);
		power_up(8'h17, 0);
		power_up(8'h65, S50);
		power_up(8'h85, S100);
		power_up(8'hC5, S200);
		end_of_test();
	end
endmodule

`default_nettype wire
